// >>> shared/fhn_pkg.sv
package fhn_pkg;
   localparam int unsigned RESET_MIN_CYCLES = 8;
   localparam logic [3:0]  RST_CNT_ZERO     = 4'h0;
   localparam logic [3:0]  RST_CNT_DONE     = 4'h8;
   localparam logic [3:0]  RST_CNT_ONE      = 4'h1;
   localparam logic [31:0] FETCH_START_ADDR = 32'h0000_0000;
   localparam int unsigned FSR_W            = 32;
   // Writable status fields, ones mark bits software can write.
   localparam logic [31:0] FSR_WRITABLE     = 32'hcfc0_0fff;
   localparam logic [31:0] FSR_RESET        = 32'h0000_0000;

   typedef struct packed {
      logic dep_found;
      logic dep_clear;
   } fhn_dep_t;

   typedef struct packed {
      logic compare_issue;
      logic compare_done;
   } fhn_cmp_t;

   typedef enum logic [2:0] {
      ST_RESET = 3'b001,
      ST_RUN   = 3'b010,
      ST_HOLD  = 3'b100
   } fhn_state_t;
endpackage

// >>> verification/fhn_hold_null_tb_top.sv
module fhn_hold_null_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import fhn_pkg::*;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        rst_req = 1'b1;
   logic        fsr_we = 1'b0;
   logic [31:0] fsr_wdata = 32'h0;
   logic [31:0] seed = 32'h0000_1efc;
   fhn_dep_t    dep = '0;
   fhn_cmp_t    cmp = '0;
   logic        reset_n;
   logic        host_nullify = 1'b0;
   logic        mem_nullify;
   logic        copro_hold_req_n;
   logic        cond_code_valid;
   logic        nullify_cycle_out;
   logic        in_reset;
   logic [31:0] fp_status_reg;
   int          n_errors = 0;
   int          n_checks = 0;
   int          n;

   fhn_hold_null DUT (.clock, .rst, .reset_n, .dep, .cmp, .fsr_wdata, .fsr_we,
      .copro_hold_req_n, .cond_code_valid, .nullify_cycle_out, .fp_status_reg, .in_reset);
   fhn_iu_model PARTNER (.clock, .rst_req, .nullify_cycle_out, .host_nullify,
      .reset_n, .mem_nullify);

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic cyc(input int k);
      repeat (k) @(posedge clock);
      #1;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      forever #5 clock = ~clock;
   end
   initial begin
      #20000;
      n_errors++;
      summarize();
   end
   initial begin
      cyc(5);
      rst = 1'b0;
      rst_req = 1'b0;
      cyc(2);
      chk({in_reset, copro_hold_req_n, nullify_cycle_out, cond_code_valid}, 32'hd);
      chk(fp_status_reg, 32'h0);
      cyc(8);
      repeat (4) begin
         fsr_wdata = xs();
         fsr_we = 1'b1;
         cyc(1);
         fsr_we = 1'b0;
         cyc(1);
         chk(fp_status_reg, fsr_wdata & FSR_WRITABLE);
      end
      // A second reset in mid-run must wipe what was written.
      rst_req = 1'b1;
      cyc(1);
      rst_req = 1'b0;
      cyc(3);
      chk({in_reset, fp_status_reg}, {1'b1, 32'h0});
      cyc(8);
      repeat (3) begin
         dep = '{1'b1, 1'b0};
         cyc(1);
         chk({copro_hold_req_n, nullify_cycle_out}, 32'h1);
         n = int'(xs() % 32'h4);
         repeat (n) begin
            cyc(1);
            chk(nullify_cycle_out, 32'h1);
         end
         dep = '{1'b0, 1'b1};
         cyc(1);
         chk({copro_hold_req_n, nullify_cycle_out}, 32'h2);
         dep = '0;
         cyc(1);
      end
      n = 1 + int'(xs() % 32'h3);
      repeat (n) begin
         cmp = '{1'b1, 1'b0};
         cyc(1);
      end
      cmp = '0;
      cyc(1);
      chk(nullify_cycle_out, 32'h1);
      chk(cond_code_valid, 32'h0);
      repeat (n) begin
         cmp = '{1'b0, 1'b1};
         cyc(1);
      end
      cmp = '0;
      repeat (4) if (cond_code_valid !== 1'b1) cyc(1);
      chk({cond_code_valid, nullify_cycle_out}, 32'h2);
      // A stray completion with nothing pending is ignored.
      cmp = '{1'b0, 1'b1};
      cyc(1);
      cmp = '0;
      cyc(2);
      chk({cond_code_valid, nullify_cycle_out}, 32'h2);
      chk(mem_nullify, 32'h0);
      host_nullify = 1'b1;
      cyc(1);
      chk(mem_nullify, 32'h1);
      host_nullify = 1'b0;
      summarize();
   end
endmodule

// >>> verification/fhn_iu_model.sv
module fhn_iu_model (
   input  wire logic clock,
   input  wire logic rst_req,
   input  wire logic nullify_cycle_out,
   input  wire logic host_nullify,
   output logic      reset_n,
   output logic      mem_nullify
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt_ff;
   always_ff @(posedge clock) begin
      if (rst_req) begin
         cnt_ff <= 4'h8;
      end else if (cnt_ff != 4'h0) begin
         cnt_ff <= cnt_ff - 4'h1;
      end
   end
   assign reset_n = (cnt_ff == 4'h0);
   assign mem_nullify = nullify_cycle_out | host_nullify;
endmodule

// >>> verilog/fhn_cmp_track.sv
module fhn_cmp_track (
   input  wire logic              clock,
   input  wire logic              rst,
   input  wire logic              pipe_clear,
   input  wire fhn_pkg::fhn_cmp_t cmp,
   output logic                   cond_code_valid
);
   import fhn_pkg::*;

   logic [3:0] pend_ff;
   logic [3:0] nxt_pend;

   always_comb begin
      nxt_pend = pend_ff;
      if (cmp.compare_issue && !cmp.compare_done) begin
         nxt_pend = pend_ff + RST_CNT_ONE;
      end else if (!cmp.compare_issue && cmp.compare_done && pend_ff != RST_CNT_ZERO) begin
         nxt_pend = pend_ff - RST_CNT_ONE;
      end
   end

   always_ff @(posedge clock) begin
      if (rst || pipe_clear) begin
         pend_ff <= RST_CNT_ZERO;
      end else begin
         pend_ff <= nxt_pend;
      end
   end

   // Valid drops while any compare is outstanding.
   assign cond_code_valid = (pend_ff == RST_CNT_ZERO);

   a_ccv_drop_issue: assert property (@(posedge clock) disable iff (rst)
      (cmp.compare_issue && !cmp.compare_done && !pipe_clear) |=> !cond_code_valid)
      else $error("valid stayed high after compare issue");
endmodule

// >>> verilog/fhn_hold_null.sv
// How it works
// - Nullify output is high every cycle the coprocessor holds the pipeline.
// - Both hold request and low condition-code-valid feed the nullify output.
// - While reset is low, pipeline clears and writable status fields go zero.
// - Clock is high in first half of a cycle, low in second.
// - Every pipeline stage starts on and is clocked by the rising edge.
// - Dependency seen in decode raises hold request next cycle until cleared.
// - Condition-code-valid drops while compares pend and returns when done.
module fhn_hold_null (
   input  wire logic              clock,
   input  wire logic              rst,
   input  wire logic              reset_n,
   input  wire fhn_pkg::fhn_dep_t dep,
   input  wire fhn_pkg::fhn_cmp_t cmp,
   input  wire logic [31:0]       fsr_wdata,
   input  wire logic              fsr_we,
   output logic                   copro_hold_req_n,
   output logic                   cond_code_valid,
   output logic                   nullify_cycle_out,
   output logic [31:0]            fp_status_reg,
   output logic                   in_reset
);
   import fhn_pkg::*;

   fhn_state_t state_ff;
   fhn_state_t nxt_state;
   logic       hold_ff;
   logic       ccv_raw;
   logic       ccv_ff;
   logic       null_ff;
   logic       pipe_clear;
   logic [31:0] fsr_ff;

   // The device reset pin is sampled at the rising edge like any other input.
   assign pipe_clear = !reset_n;

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_RESET: if (reset_n) nxt_state = ST_RUN;
         ST_RUN: begin
            if (!reset_n) nxt_state = ST_RESET;
            else if (dep.dep_found && !dep.dep_clear) nxt_state = ST_HOLD;
         end
         ST_HOLD: begin
            if (!reset_n) nxt_state = ST_RESET;
            else if (dep.dep_clear) nxt_state = ST_RUN;
         end
         default: nxt_state = ST_RESET;
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_ff <= ST_RESET;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge clock) begin
      if (rst || pipe_clear) begin
         hold_ff <= 1'b0;
      end else begin
         hold_ff <= (nxt_state == ST_HOLD);
      end
   end

   fhn_cmp_track u_cmp (
      .clock           (clock),
      .rst             (rst),
      .pipe_clear      (pipe_clear),
      .cmp             (cmp),
      .cond_code_valid (ccv_raw)
   );

   always_ff @(posedge clock) begin
      if (rst || pipe_clear) begin
         ccv_ff <= 1'b1;
      end else begin
         ccv_ff <= ccv_raw;
      end
   end

   always_ff @(posedge clock) begin
      if (rst || pipe_clear) begin
         null_ff <= 1'b0;
      end else begin
         null_ff <= (nxt_state == ST_HOLD) || !ccv_raw;
      end
   end

   // writable fields cleared
   // The system reset also clears the read-only bits so they never start unknown.
   always_ff @(posedge clock) begin
      if (rst) begin
         fsr_ff <= FSR_RESET;
      end else if (pipe_clear) begin
         fsr_ff <= fsr_ff & ~FSR_WRITABLE;
      end else if (fsr_we) begin
         fsr_ff <= (fsr_ff & ~FSR_WRITABLE) | (fsr_wdata & FSR_WRITABLE);
      end
   end

   logic in_rst_ff;
   always_ff @(posedge clock) begin
      if (rst) begin
         in_rst_ff <= 1'b1;
      end else begin
         in_rst_ff <= pipe_clear;
      end
   end

   assign copro_hold_req_n  = !hold_ff;
   assign cond_code_valid   = ccv_ff;
   assign nullify_cycle_out = null_ff;
   assign fp_status_reg     = fsr_ff;
   assign in_reset          = in_rst_ff;

   sequence s_hold_or_wait;
      !copro_hold_req_n || !cond_code_valid;
   endsequence

   a_null_tracks_hold: assert property (@(posedge clock) disable iff (rst)
      s_hold_or_wait |-> nullify_cycle_out)
      else $error("nullify low while holding");
   a_null_drops_idle: assert property (@(posedge clock) disable iff (rst)
      (copro_hold_req_n && cond_code_valid) |-> !nullify_cycle_out)
      else $error("nullify high without hold");
   a_hold_next_cycle: assert property (@(posedge clock) disable iff (rst)
      (reset_n && state_ff == ST_RUN && dep.dep_found && !dep.dep_clear)
      |=> !copro_hold_req_n)
      else $error("hold request missing after dependency");
   a_fsr_reset_zero: assert property (@(posedge clock) disable iff (rst)
      !reset_n |=> ((fp_status_reg & FSR_WRITABLE) == FSR_RESET))
      else $error("writable status bits not zero after reset");
   a_null_in_reset: assert property (@(posedge clock) disable iff (rst)
      !reset_n |=> !nullify_cycle_out ##1 !nullify_cycle_out || !reset_n)
      else $error("nullify high around reset");

   sequence s_compare_taken;
      (reset_n && cmp.compare_issue && !cmp.compare_done) ##1 reset_n;
   endsequence

   sequence s_dep_release;
      reset_n && state_ff == ST_HOLD && dep.dep_clear;
   endsequence

   a_ccv_low_compare: assert property (@(posedge clock) disable iff (rst)
      s_compare_taken |=> !cond_code_valid)
      else $error("condition valid high with compare pending");
   a_hold_release: assert property (@(posedge clock) disable iff (rst)
      s_dep_release |=> copro_hold_req_n)
      else $error("hold request stuck after dependency cleared");
endmodule
